// >>> rtl/mdc_top.sv
// Six-channel DMA control: register slave, trigger handling and transfer engine
`timescale 1ns/1ns
`include "mdc_defs.svh"

// ==========================================================================
// Overview of operation
// R1 - Clearing module enable aborts all channel work
// R2 - Priority select: one round robin, zero fixed
// R3 - Dummy write mode adds write to source
// R4 - Restore bit reloads pointers and counter at start
// R5 - Repeated modes always reload at operation start
// R6 - Soft request triggers; cleared when operation completes
// R7 - Source step: hold, increment, decrement by size
// R8 - Destination step: hold, increment, decrement by size
// R9 - Transfer kind selects one of four modes
// R10 - Size bit: one byte, zero word
// R11 - Channel runs only while channel-on set
// R12 - Buffer pending flag shows unwritten staging data
// R13 - Trigger select maps events; zero triggers nothing
// R14 - Upper limit flag on access above limit
// R15 - Lower limit flag below limit, above SFRs
// R16 - Limits checked at the actual access
// R17 - Finished flag set on completion, cleared at start
// R18 - Midpoint flag when counter reaches half way
// R19 - Overrun flag on trigger while still busy
// R20 - Midpoint enable adds interrupt at half way
// R21 - Software flag writes raise no interrupt
// R22 - Four module registers, five per channel
// R23 - Limit violation aborts transaction and interrupts
// R24 - Continuous runs counter transfers, one-shot one
// R25 - Round robin rotates; fixed favours lowest channel
// R26 - Address bit zero selects byte lane
// R27 - Data moves through the single staging buffer
// R28 - Unimplemented bits read zero, ignore writes
module mdc_top (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Avalon-MM register slave
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Peripheral trigger events, one-cycle pulses
  input wire logic [63:0] i_trig,
  // Data bus master
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [15:0] o_mem_addr,
  output logic [15:0] o_mem_wdata,
  output logic [1:0] o_mem_be,
  input wire logic i_mem_ack,
  input wire logic [15:0] i_mem_rdata,
  // Per-channel interrupt pulses
  output logic [5:0] o_irq
);

  localparam int NCH = `MDC_NCH;

  // ==========================================================================
  // Declarations
  logic rst_s1_r, rst_n_r;
  mdc_pkg::mdc_word_t con_r, con_nxt, lhi_r, lhi_nxt, llo_r, llo_nxt, buf_r, buf_nxt;
  mdc_pkg::mdc_word_t ctl_r [NCH];
  mdc_pkg::mdc_word_t ctl_nxt [NCH];
  mdc_pkg::mdc_word_t int_r [NCH];
  mdc_pkg::mdc_word_t int_nxt [NCH];
  mdc_pkg::mdc_word_t src_r [NCH];
  mdc_pkg::mdc_word_t src_nxt [NCH];
  mdc_pkg::mdc_word_t dst_r [NCH];
  mdc_pkg::mdc_word_t dst_nxt [NCH];
  mdc_pkg::mdc_word_t cnt_r [NCH];
  mdc_pkg::mdc_word_t cnt_nxt [NCH];
  mdc_pkg::mdc_word_t ssv_r [NCH];
  mdc_pkg::mdc_word_t ssv_nxt [NCH];
  mdc_pkg::mdc_word_t dsv_r [NCH];
  mdc_pkg::mdc_word_t dsv_nxt [NCH];
  mdc_pkg::mdc_word_t csv_r [NCH];
  mdc_pkg::mdc_word_t csv_nxt [NCH];
  logic [NCH-1:0] act_r, act_nxt, pend_r, pend_nxt, irq_r, irq_nxt, hit, swreq, areq;
  mdc_pkg::mdc_state_t st_r, st_nxt, tgt;
  logic [2:0] cur_r, cur_nxt, gnt_ch, ech;
  logic req_r, req_nxt, we_r, we_nxt, gnt_v, lw, load, kill;
  logic ev_start, ev_rd, ev_fin, ev_abort;
  logic [1:0] ev_lim, be_r, be_nxt;
  logic [15:0] addr_r, addr_nxt, wd_r, wd_nxt, na, rmux, wval, rd_val, src_go, cdec;
  logic wait_r, bus_wr, sel_ch, acc, bsz, rl;
  logic [2:0] sel_n, sel_sub;
  logic [6:0] dsel;
  logic [31:0] rdat_r;

  // ==========================================================================
  // Functions

  // Pointer step after a transfer, one byte or one word
  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m,
                                       input logic b);
    logic [15:0] d;
    d = b ? 16'h0001 : 16'h0002;
    step = (m == `MDC_STEP_INC) ? a + d : (m == `MDC_STEP_DEC) ? a - d : a;
  endfunction : step

  // Limit check of one address: {above upper, below lower}
  function automatic logic [1:0] lim(input logic [15:0] a, input logic [15:0] hi,
                                     input logic [15:0] lo);
    lim = {(a > `MDC_SFR_TOP) && (a > hi), (a > `MDC_SFR_TOP) && (a < lo)};
  endfunction : lim

  // Register address decode: {channel hit, channel, register within channel}
  function automatic logic [6:0] dec(input logic [5:0] a);
    logic [5:0] base;
    dec = 7'h00;
    for (int n = 0; n < NCH; n++) begin
      base = `MDC_IX_CH0 + 6'(n) * `MDC_CH_STRIDE;
      if (a >= base && a < base + `MDC_CH_STRIDE) dec = {1'b1, 3'(n), 3'(a - base)};
    end
  endfunction : dec

  // ==========================================================================
  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ==========================================================================
  // Avalon slave: every access answers in the second cycle
  assign dsel = dec(i_avs_address);
  assign sel_ch = dsel[6];
  assign sel_n = dsel[5:3];
  assign sel_sub = dsel[2:0];
  assign bus_wr = i_avs_write && !wait_r;
  // Byte enables merge into the current value so unwritten lanes keep their bits
  assign wval = (rmux & ~{{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}}) |
                (i_avs_writedata[15:0] & {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}});

  // Read selection; unmapped words and upper bits read zero [R22] [R28]
  always_comb begin
    rmux = 16'h0000;
    if (sel_ch) begin
      case (sel_sub)
        `MDC_SUB_CTL: rmux = ctl_r[sel_n];
        `MDC_SUB_INT: rmux = int_r[sel_n];
        `MDC_SUB_SRC: rmux = src_r[sel_n];
        `MDC_SUB_DST: rmux = dst_r[sel_n];
        `MDC_SUB_CNT: rmux = cnt_r[sel_n];
        default: rmux = 16'h0000;
      endcase
    end else begin
      case (i_avs_address)
        `MDC_IX_CON: rmux = con_r;
        `MDC_IX_LHI: rmux = lhi_r;
        `MDC_IX_LLO: rmux = llo_r;
        `MDC_IX_BUF: rmux = buf_r;
        default: rmux = 16'h0000;
      endcase
    end
  end

  // Handshake and read capture
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wait_r <= 1'b1;
      rdat_r <= 32'h0000_0000;
    end else begin
      wait_r <= !((i_avs_read || i_avs_write) && wait_r);
      if (i_avs_read && wait_r) rdat_r <= {16'h0000, rmux};
    end
  end

  // Module-level registers; the staging buffer is read only
  assign con_nxt = (bus_wr && !sel_ch && i_avs_address == `MDC_IX_CON) ?
                   (wval & `MDC_CON_MASK) : con_r; // [R28]
  assign lhi_nxt = (bus_wr && !sel_ch && i_avs_address == `MDC_IX_LHI) ? wval : lhi_r;
  assign llo_nxt = (bus_wr && !sel_ch && i_avs_address == `MDC_IX_LLO) ? wval : llo_r;

  // ==========================================================================
  // Triggers: peripheral events selected per channel, and software requests
  for (genvar g = 0; g < NCH; g++) begin : g_trig
    assign hit[g] = con_r[`MDC_CON_EN] && ctl_r[g][`MDC_CH_ON] &&
                    (int_r[g][13:8] != 6'h00) && i_trig[int_r[g][13:8]]; // [R13]
    assign swreq[g] = bus_wr && sel_ch && sel_n == 3'(g) && sel_sub == `MDC_SUB_CTL &&
                      wval[`MDC_CH_SREQ] && !ctl_r[g][`MDC_CH_SREQ]; // [R6]
    assign areq[g] = pend_r[g] && ctl_r[g][`MDC_CH_ON] && con_r[`MDC_CON_EN]; // [R11]
  end

  // Arbitration among pending channels [R2] [R25]
  mdc_arb u_arb (
    .i_clk(i_clk),
    .i_rst_n(rst_n_r),
    .i_req(areq),
    .i_rr(con_r[`MDC_CON_RR]),
    .i_take(ev_start),
    .o_valid(gnt_v),
    .o_ch(gnt_ch)
  );

  // ==========================================================================
  // Transfer engine
  assign acc = req_r && i_mem_ack;
  assign ech = (st_r == mdc_pkg::ST_IDLE) ? gnt_ch : cur_r;
  assign bsz = ctl_r[ech][`MDC_CH_SIZE]; // [R10]
  assign kill = (st_r != mdc_pkg::ST_IDLE) &&
                (!con_r[`MDC_CON_EN] || !ctl_r[cur_r][`MDC_CH_ON]); // [R1] [R11]
  // New session of a repeated mode, or with restore set, starts from saved values
  assign rl = !act_r[gnt_ch] &&
              (ctl_r[gnt_ch][`MDC_CH_RELOAD] || ctl_r[gnt_ch][`MDC_CH_TRM]); // [R4] [R5]
  assign src_go = rl ? ssv_r[gnt_ch] : src_r[gnt_ch];
  // Byte reads take the lane picked by address bit zero [R26]
  assign rd_val = !bsz ? i_mem_rdata :
                  {8'h00, addr_r[0] ? i_mem_rdata[15:8] : i_mem_rdata[7:0]};
  assign cdec = cnt_r[cur_r] - 16'h0001;

  // Sequencing: read source into the buffer, write destination, optional dummy write
  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    req_nxt = req_r;
    we_nxt = we_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    be_nxt = be_r;
    buf_nxt = buf_r;
    ev_start = 1'b0;
    ev_rd = 1'b0;
    ev_fin = 1'b0;
    ev_abort = 1'b0;
    na = 16'h0000;
    load = 1'b0;
    lw = 1'b0;
    tgt = mdc_pkg::ST_IDLE;
    if (kill) begin
      st_nxt = mdc_pkg::ST_IDLE; // [R1]
      req_nxt = 1'b0;
    end else begin
      unique case (st_r)
        mdc_pkg::ST_IDLE: if (gnt_v) begin
          cur_nxt = gnt_ch;
          ev_start = 1'b1;
          na = src_go;
          load = 1'b1;
          tgt = mdc_pkg::ST_READ;
        end
        mdc_pkg::ST_READ: if (acc) begin
          ev_rd = 1'b1;
          buf_nxt = rd_val; // [R27]
          na = dst_r[cur_r];
          load = 1'b1;
          lw = 1'b1;
          tgt = mdc_pkg::ST_WRITE;
        end
        mdc_pkg::ST_WRITE: if (acc) begin
          if (ctl_r[cur_r][`MDC_CH_DUMMY_WRITE_MODE]) begin
            na = src_r[cur_r]; // [R3]
            load = 1'b1;
            lw = 1'b1;
            tgt = mdc_pkg::ST_NULL;
          end else begin
            ev_fin = 1'b1;
          end
        end
        mdc_pkg::ST_NULL: if (acc) ev_fin = 1'b1;
      endcase
    end
    // Each address is checked as it goes out, never ahead of time [R16]
    ev_lim = load ? lim(na, lhi_r, llo_r) : 2'b00;
    if (load && (|ev_lim)) begin
      ev_abort = 1'b1; // [R23]
      st_nxt = mdc_pkg::ST_IDLE;
      req_nxt = 1'b0;
    end else if (load) begin
      st_nxt = tgt;
      req_nxt = 1'b1;
      we_nxt = lw;
      addr_nxt = na;
      wd_nxt = bsz ? {buf_nxt[7:0], buf_nxt[7:0]} : buf_nxt;
      be_nxt = !bsz ? 2'b11 : (na[0] ? 2'b10 : 2'b01); // [R26]
    end else if (ev_fin || acc) begin
      st_nxt = ev_fin ? mdc_pkg::ST_IDLE : st_nxt;
      req_nxt = 1'b0;
    end
  end

  // ==========================================================================
  // Channel registers: software writes first, hardware events after so sets win
  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      ctl_nxt[n] = ctl_r[n];
      int_nxt[n] = int_r[n];
      src_nxt[n] = src_r[n];
      dst_nxt[n] = dst_r[n];
      cnt_nxt[n] = cnt_r[n];
      ssv_nxt[n] = ssv_r[n];
      dsv_nxt[n] = dsv_r[n];
      csv_nxt[n] = csv_r[n];
      act_nxt[n] = act_r[n];
      pend_nxt[n] = pend_r[n];
      irq_nxt[n] = 1'b0;
      if (bus_wr && sel_ch && sel_n == 3'(n)) begin
        case (sel_sub)
          `MDC_SUB_CTL: ctl_nxt[n] = wval & `MDC_CH_MASK; // [R28]
          `MDC_SUB_INT: int_nxt[n] = (int_r[n] & ~`MDC_IN_MASK) | (wval & `MDC_IN_MASK); // [R21]
          `MDC_SUB_SRC: begin
            src_nxt[n] = wval;
            ssv_nxt[n] = wval;
          end
          `MDC_SUB_DST: begin
            dst_nxt[n] = wval;
            dsv_nxt[n] = wval;
          end
          `MDC_SUB_CNT: begin
            cnt_nxt[n] = wval;
            csv_nxt[n] = wval;
          end
          default: ;
        endcase
      end
      // Engine off or channel off drops all work of the channel [R1] [R11]
      if (!con_r[`MDC_CON_EN] || !ctl_r[n][`MDC_CH_ON]) begin
        pend_nxt[n] = 1'b0;
        act_nxt[n] = 1'b0;
      end
      if (ech == 3'(n) && ev_start) begin
        act_nxt[n] = 1'b1;
        if (!act_r[n]) int_nxt[n][`MDC_IN_DONE] = 1'b0; // [R17]
        if (rl) begin
          src_nxt[n] = ssv_r[n]; // [R4] [R5]
          dst_nxt[n] = dsv_r[n];
          cnt_nxt[n] = csv_r[n];
        end
      end
      if (ech == 3'(n) && ev_rd) int_nxt[n][`MDC_IN_PEND] = 1'b1; // [R12]
      if (ech == 3'(n) && ev_abort) begin
        int_nxt[n][`MDC_IN_HI] = int_nxt[n][`MDC_IN_HI] | ev_lim[1]; // [R14]
        int_nxt[n][`MDC_IN_LO] = int_nxt[n][`MDC_IN_LO] | ev_lim[0]; // [R15]
        act_nxt[n] = 1'b0; // [R23]
        pend_nxt[n] = 1'b0;
        ctl_nxt[n][`MDC_CH_SREQ] = 1'b0;
        irq_nxt[n] = 1'b1;
      end
      if (ech == 3'(n) && ev_fin) begin
        int_nxt[n][`MDC_IN_PEND] = 1'b0; // [R12]
        src_nxt[n] = step(src_r[n], ctl_r[n][7:6], ctl_r[n][`MDC_CH_SIZE]); // [R7]
        dst_nxt[n] = step(dst_r[n], ctl_r[n][5:4], ctl_r[n][`MDC_CH_SIZE]); // [R8]
        cnt_nxt[n] = cdec;
        if (cdec == (csv_r[n] >> 1)) begin
          int_nxt[n][`MDC_IN_HALF] = 1'b1; // [R18]
          if (int_r[n][`MDC_IN_HEN]) irq_nxt[n] = 1'b1; // [R20]
        end
        if (cdec == 16'h0000) begin
          int_nxt[n][`MDC_IN_DONE] = 1'b1; // [R17]
          irq_nxt[n] = 1'b1; // [R20]
          act_nxt[n] = 1'b0;
          pend_nxt[n] = 1'b0;
          ctl_nxt[n][`MDC_CH_SREQ] = 1'b0; // [R6]
          if (!ctl_r[n][`MDC_CH_TRM]) ctl_nxt[n][`MDC_CH_ON] = 1'b0; // [R9]
        end else if (!ctl_r[n][3]) begin
          pend_nxt[n] = 1'b0; // [R24]
          ctl_nxt[n][`MDC_CH_SREQ] = 1'b0; // [R6]
        end
      end
      // A new trigger while the previous one is still served is an overrun
      if (hit[n] || swreq[n]) begin
        if (pend_r[n] && !(ech == 3'(n) && (ev_fin || ev_abort))) begin
          int_nxt[n][`MDC_IN_OVR] = 1'b1; // [R19]
          irq_nxt[n] = 1'b1;
        end
        pend_nxt[n] = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      con_r <= `MDC_RST_REG;
      lhi_r <= `MDC_RST_LHI;
      llo_r <= `MDC_RST_LLO;
      buf_r <= `MDC_RST_REG;
      act_r <= '0;
      pend_r <= '0;
      irq_r <= '0;
    end else begin
      con_r <= con_nxt;
      lhi_r <= lhi_nxt;
      llo_r <= llo_nxt;
      buf_r <= buf_nxt;
      act_r <= act_nxt;
      pend_r <= pend_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Per-channel register file; reset test stays outermost so the flops map to async reset
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int n = 0; n < NCH; n++) begin
        ctl_r[n] <= `MDC_RST_REG;
        int_r[n] <= `MDC_RST_REG;
        src_r[n] <= `MDC_RST_REG;
        dst_r[n] <= `MDC_RST_REG;
        cnt_r[n] <= `MDC_RST_REG;
        ssv_r[n] <= `MDC_RST_REG;
        dsv_r[n] <= `MDC_RST_REG;
        csv_r[n] <= `MDC_RST_REG;
      end
    end else begin
      for (int n = 0; n < NCH; n++) begin
        ctl_r[n] <= ctl_nxt[n];
        int_r[n] <= int_nxt[n];
        src_r[n] <= src_nxt[n];
        dst_r[n] <= dst_nxt[n];
        cnt_r[n] <= cnt_nxt[n];
        ssv_r[n] <= ssv_nxt[n];
        dsv_r[n] <= dsv_nxt[n];
        csv_r[n] <= csv_nxt[n];
      end
    end
  end

  // Engine registers
  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= mdc_pkg::ST_IDLE;
      cur_r <= 3'h0;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= 16'h0000;
      wd_r <= 16'h0000;
      be_r <= 2'b00;
    end else begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      req_r <= req_nxt;
      we_r <= we_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      be_r <= be_nxt;
    end
  end

  // Outputs straight from flops
  assign o_avs_readdata = rdat_r;
  assign o_avs_waitrequest = wait_r;
  assign o_mem_req = req_r;
  assign o_mem_we = we_r;
  assign o_mem_addr = addr_r;
  assign o_mem_wdata = wd_r;
  assign o_mem_be = be_r;
  assign o_irq = irq_r;

  // ==========================================================================
  // Checks
  a_disable_abort: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R1]
    !con_r[`MDC_CON_EN] |=> (st_r == mdc_pkg::ST_IDLE && !req_r))
    else $error("engine still busy after module disable");
  a_fixed_pick: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R25]
    (gnt_v && !con_r[`MDC_CON_RR]) |-> ((areq & ((6'h01 << gnt_ch) - 6'h01)) == 6'h00))
    else $error("fixed scheme skipped a lower channel");
  a_null_follow: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R3]
    (st_r == mdc_pkg::ST_WRITE && acc && !kill && ctl_r[cur_r][`MDC_CH_DUMMY_WRITE_MODE]) |=>
    ((st_r == mdc_pkg::ST_NULL && we_r && req_r) || (st_r == mdc_pkg::ST_IDLE && !req_r)))
    else $error("dummy write missing");
  a_word_lanes: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R10]
    (req_r && !ctl_r[cur_r][`MDC_CH_SIZE]) |-> (be_r == 2'b11))
    else $error("word transfer without both lanes");
  a_byte_lane: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R26]
    (req_r && ctl_r[cur_r][`MDC_CH_SIZE]) |-> (be_r == (addr_r[0] ? 2'b10 : 2'b01)))
    else $error("byte lane does not follow address bit zero");
  a_grant_on: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R11]
    ev_start |-> (ctl_r[gnt_ch][`MDC_CH_ON] && con_r[`MDC_CON_EN]))
    else $error("disabled channel started");
  a_pend_flag: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R12]
    ev_rd |=> int_r[cur_r][`MDC_IN_PEND] ##1 (int_r[cur_r][`MDC_IN_PEND] || !act_r[cur_r] ||
    st_r != mdc_pkg::ST_WRITE || $past(ev_fin)))
    else $error("buffer pending flag not set after read");
  a_limit_abort: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R23]
    ev_abort |=> (!req_r && o_irq != 6'h00 && st_r == mdc_pkg::ST_IDLE))
    else $error("limit violation not aborted with interrupt");
  a_bus_answer: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R22]
    ((i_avs_read || i_avs_write) && wait_r) |=> !wait_r ##1 wait_r)
    else $error("register access not answered in one cycle");
  a_sw_no_irq: assert property (@(posedge i_clk) disable iff (!rst_n_r) // [R21]
    (bus_wr && sel_sub == `MDC_SUB_INT && !ev_fin && !ev_abort && hit == 6'h00 &&
    swreq == 6'h00) |=> (o_irq == 6'h00))
    else $error("software flag write raised an interrupt");

endmodule : mdc_top

// >>> rtl/mdc_defs.svh
// Register map, field positions, reset values and limits of the DMA control block
`ifndef MDC_DEFS_SVH
`define MDC_DEFS_SVH

// ==========================================================================
// Sizes
`define MDC_NCH 6

// ==========================================================================
// Register word indices on the Avalon address
`define MDC_IX_CON 6'h00
`define MDC_IX_LHI 6'h01
`define MDC_IX_LLO 6'h02
`define MDC_IX_BUF 6'h03
`define MDC_IX_CH0 6'h04
`define MDC_CH_STRIDE 6'h05
`define MDC_SUB_CTL 3'h0
`define MDC_SUB_INT 3'h1
`define MDC_SUB_SRC 3'h2
`define MDC_SUB_DST 3'h3
`define MDC_SUB_CNT 3'h4

// ==========================================================================
// Engine control fields
`define MDC_CON_EN 15
`define MDC_CON_RR 0
`define MDC_CON_MASK 16'h8001

// ==========================================================================
// Channel control fields
`define MDC_CH_DUMMY_WRITE_MODE 10
`define MDC_CH_RELOAD 9
`define MDC_CH_SREQ 8
`define MDC_CH_SAM 6
`define MDC_CH_DAM 4
`define MDC_CH_TRM 2
`define MDC_CH_SIZE 1
`define MDC_CH_ON 0
`define MDC_CH_MASK 16'h07ff

// ==========================================================================
// Channel interrupt fields
`define MDC_IN_PEND 15
`define MDC_IN_TSEL 8
`define MDC_IN_HI 7
`define MDC_IN_LO 6
`define MDC_IN_DONE 5
`define MDC_IN_HALF 4
`define MDC_IN_OVR 3
`define MDC_IN_HEN 0
`define MDC_IN_MASK 16'h3ff9

// ==========================================================================
// Address steps, reset values and the special-function range
`define MDC_STEP_INC 2'h1
`define MDC_STEP_DEC 2'h2
`define MDC_RST_REG 16'h0000
`define MDC_RST_LHI 16'hffff
`define MDC_RST_LLO 16'h0800
`define MDC_SFR_TOP 16'h07ff

`endif

// >>> rtl/mdc_pkg.sv
// Types shared by the DMA control block
package mdc_pkg;

  // Transfer engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10,
    ST_NULL = 2'b11
  } mdc_state_t;

  // One 16-bit register
  typedef logic [15:0] mdc_word_t;

endpackage : mdc_pkg

// >>> rtl/mdc_arb.sv
// Channel arbiter with fixed and round-robin schemes
`timescale 1ns/1ns

module mdc_arb (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Requests
  input wire logic [5:0] i_req,
  input wire logic i_rr,
  input wire logic i_take,
  // Grant
  output logic o_valid,
  output logic [2:0] o_ch
);

  logic [2:0] last_r;
  logic [2:0] first;

  // First requester at or after a start position, wrapping at six
  function automatic logic [2:0] pick(input logic [5:0] req, input logic [2:0] from);
    logic [3:0] s;
    pick = from;
    for (int i = 5; i >= 0; i--) begin
      s = {1'b0, from} + 4'(i);
      if (s >= 4'h6) s = s - 4'h6;
      if (req[s[2:0]]) pick = s[2:0];
    end
  endfunction : pick

  // Fixed always starts at channel 0; round robin starts past the last winner
  assign first = !i_rr ? 3'h0 : (last_r == 3'h5) ? 3'h0 : last_r + 3'h1;
  assign o_ch = pick(i_req, first);
  assign o_valid = |i_req;

  // Reset to the top channel so channel 0 wins the first collision
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_r <= 3'h5;
    end else if (i_take) begin
      last_r <= o_ch;
    end
  end

endmodule : mdc_arb

// >>> tb/mdc_mem.sv
// Data memory model that answers the block's bus master
`timescale 1ns/1ns
module mdc_mem (
  // Clock
  input wire logic i_clk,
  // Request from the block
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  // Answer and record of the last write
  output logic o_ack,
  output logic [15:0] o_rdata,
  output logic [15:0] o_waddr,
  output logic [15:0] o_wval
);
  // Ack comes one cycle late, so the master must hold its request
  initial o_ack = 1'b0;
  initial o_waddr = 16'h0000;
  initial o_wval = 16'h0000;
  always @(posedge i_clk) begin
    o_ack <= i_req && !o_ack;
    if (i_req && o_ack && i_we) begin
      o_waddr <= i_addr;
      o_wval <= i_wdata;
    end
  end
  // During ack the data is the inverted address, so a stale capture never matches
  assign o_rdata = o_ack ? ~i_addr : i_addr;
endmodule : mdc_mem

// >>> tb/mdc_top_tb_top.sv
// Self-checking bench for the DMA control block
`timescale 1ns/1ns
module mdc_top_tb_top;
  // ==========================================================
  // Stimulus and observed signals
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [63:0] trig = 64'h0;
  logic [31:0] rdat;
  logic wq, req, we, ack;
  logic [15:0] ma, mw, mr, waddr, wval;
  logic [1:0] be;
  logic [5:0] irq;
  int errors = 0;
  int check_count = 0;
  always #10 i_clk = ~i_clk;
  mdc_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'h3), .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
    .i_trig(trig), .o_mem_req(req), .o_mem_we(we), .o_mem_addr(ma),
    .o_mem_wdata(mw), .o_mem_be(be), .i_mem_ack(ack), .i_mem_rdata(mr),
    .o_irq(irq));
  mdc_mem mem_u (.i_clk(i_clk), .i_req(req), .i_we(we), .i_addr(ma),
    .i_wdata(mw), .o_ack(ack), .o_rdata(mr), .o_waddr(waddr), .o_wval(wval));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic test_done;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge i_clk);
    adr <= a;
    wd <= {16'h0, d};
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wq !== 1'b0 && n < 50);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 50) begin
      errors++;
      test_done();
    end
  endtask : bus
  task automatic w16(input logic [5:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : w16
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, q);
    check(q, e);
  endtask : rc
  // Bounded wait for a channel's interrupt pulse
  task automatic wirq(input int c);
    int n;
    n = 0;
    while (irq[c] !== 1'b1 && n < 99) begin
      @(posedge i_clk);
      n++;
    end
    if (n == 99) begin
      errors++;
      test_done();
    end
  endtask : wirq
  // ==========================================================
  // Scenarios
  // Soft-requested one-shot word move, both pointers stepping up
  task automatic soft_move;
    w16(6'h06, 16'h0900);
    w16(6'h07, 16'h0a00);
    w16(6'h08, 16'h0001);
    w16(6'h04, 16'h0151);
    wirq(0);
    check(waddr, 16'h0a00);
    check(wval, {16'h0000, ~16'h0900});
    rc(6'h06, 32'h0902);
    rc(6'h07, 32'h0a02);
    rc(6'h04, 32'h0050);
    rc(6'h05, 32'h0030);
  endtask : soft_move
  // Soft-requested byte move on channel 2 with dummy write, source stepping down
  task automatic null_byte;
    w16(6'h10, 16'h0901);
    w16(6'h11, 16'h0a00);
    w16(6'h12, 16'h0001);
    w16(6'h0e, 16'h0583);
    wirq(2);
    check(waddr, 16'h0901);
    // Upper byte of the inverted source address, repeated in both lanes
    check(wval, 16'hf6f6);
    rc(6'h10, 32'h0900);
    rc(6'h11, 32'h0a00);
    rc(6'h0e, 32'h0482);
  endtask : null_byte
  // Peripheral trigger on channel 1 with source above the upper limit
  task automatic limit_abort;
    w16(6'h01, 16'h1000);
    w16(6'h0a, 16'h0500);
    w16(6'h0b, 16'h2000);
    w16(6'h09, 16'h0001);
    @(posedge i_clk);
    trig <= 64'h20;
    @(posedge i_clk);
    trig <= 64'h0;
    wirq(1);
    rc(6'h0a, 32'h0580);
  endtask : limit_abort
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    rc(6'h01, 32'hffff);
    rc(6'h02, 32'h0800);
    rc(6'h3f, 32'h0000);
    w16(6'h00, 16'hffff);
    rc(6'h00, 32'h8001);
    soft_move();
    limit_abort();
    null_byte();
    test_done();
  end
endmodule : mdc_top_tb_top
